// ### logic/uhi_pkg.sv
// Shared constants for the UART holding and interrupt enable block.
// Assumes an 8-bit host bus with three address lines.
package uhi_pkg;
  // ==========================================================
  // Register offsets on the three address lines
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_ISR_FCR = 3'h2;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  // ==========================================================
  // Interrupt enable fields
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam int IER_SLEEP = 4;
  localparam int IER_XOFF = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  // ==========================================================
  // FIFO control, modem control, line status fields
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;
  localparam int MCR_RTS = 1;
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_PE = 2;
  localparam int LSR_FE = 3;
  localparam int LSR_BI = 4;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int LSR_FERR = 7;
  // ==========================================================
  // Identify register layout: bit 0 high means nothing pending
  localparam int ISR_NONE = 0;
  localparam int ISR_LS = 1;
  localparam int ISR_RX = 2;
  localparam int ISR_TX = 3;
  localparam int ISR_MS = 4;
  localparam int ISR_XOFF = 5;
  localparam int ISR_CTS = 6;
  localparam int ISR_RTS = 7;
  // ==========================================================
  // Reset values, trigger levels, frame and pin layout
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] TRIG_L0 = 8'h08;
  localparam logic [7:0] TRIG_L1 = 8'h10;
  localparam logic [7:0] TRIG_L2 = 8'h18;
  localparam logic [7:0] TRIG_L3 = 8'h1C;
  localparam int DATA_BITS = 8;
  localparam int CHR_FE = 8;
  localparam int CHR_BRK = 9;
  localparam int CHR_W = 10;
  localparam int PIN_RX = 0;
  localparam int PIN_CTS = 1;
  localparam int PIN_DSR = 2;
  localparam int PIN_RI = 3;
  localparam int PIN_CD = 4;
  localparam int PIN_N = 5;
  localparam logic [4:0] PIN_RST = 5'h01;
endpackage : uhi_pkg

// ### logic/uhi_top.sv
// UART channel: holding registers, FIFOs, start validation, interrupts.
// Assumes host strobes are synchronous to sys_clk_in, one cycle each.
`timescale 1ns/1ns

// ==========================================================
// Three-stage pin synchroniser with agreement filter
module uhi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // First stage feeds only the second
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      pin_out <= RST;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_out <= (s2_r == s3_r) ? s3_r : pin_out; // Counts once they agree
    end
  end
endmodule : uhi_sync

// ==========================================================
// Flip-flop FIFO with valid/ready on both sides
module uhi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2,
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [CW-1:0] count_out
);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic push;
  logic pop;

  if (DEPTH < 2)
  begin : g_bad_depth
    $error("uhi_fifo needs at least two entries");
  end

  // Honest full and empty from the fill count
  assign in_ready_out = (count_out != CW'(DEPTH));
  assign out_valid_out = (count_out != '0);
  assign out_data_out = mem_r[rd_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Storage and write pointer
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || flush_in)
      wr_r <= '0;
    else if (push)
    begin
      mem_r[wr_r] <= in_data_in;
      wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
  end

  // Read pointer and fill count
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || flush_in)
    begin
      rd_r <= '0;
      count_out <= '0;
    end
    else
    begin
      if (pop)
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      if (push && !pop)
        count_out <= count_out + 1'b1;
      else if (pop && !push)
        count_out <= count_out - 1'b1;
    end
  end
endmodule : uhi_fifo

module uhi_top #(
  parameter int DIV16 = 27,
  parameter int FIFO_DEPTH = 128,
  parameter logic [7:0] XOFF_CHAR = 8'h13
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [2:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [7:0] bus_rdata_out,
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  input wire logic clear_to_send_in,
  input wire logic data_set_ready_in,
  input wire logic ring_indicator_in,
  input wire logic carrier_detect_in,
  output logic request_to_send_out,
  output logic channel_irq_out,
  output logic sleep_out
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int BIT_CLKS = 16 * DIV16;
  localparam int TW = $clog2(BIT_CLKS);
  localparam logic [TW-1:0] BIT_LAST = TW'(BIT_CLKS - 1);
  localparam logic [TW-1:0] START_LAST = TW'((15 * DIV16) / 2 - 1);
  localparam logic [3:0] DATA_LAST = 4'(uhi_pkg::DATA_BITS - 1);
  localparam logic [3:0] TX_LAST = 4'(uhi_pkg::DATA_BITS + 1);

  if (DIV16 < 2 || FIFO_DEPTH < 32 || FIFO_DEPTH > 255)
  begin : g_bad_param
    $error("uhi_top needs DIV16 >= 2 and FIFO_DEPTH in 32..255");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhi_rx_e;
  typedef enum logic {TX_IDLE, TX_SHIFT} uhi_tx_e;

  logic [uhi_pkg::PIN_N-1:0] pins;
  logic [uhi_pkg::PIN_N-1:0] pins_prev_r;
  logic [7:0] ier_r;
  logic [7:0] fcr_r;
  logic [7:0] mcr_r;
  logic fifo_en;
  logic wr_data, wr_ier, wr_fcr, wr_mcr;
  logic rd_data, rd_isr, rd_lsr, rd_msr;
  logic tx_flush, rx_flush;
  logic [7:0] trig;
  // Transmit side
  logic tx_in_ready, tx_out_valid, tx_pop, tx_empty, tx_empty_prev_r;
  logic [7:0] tx_out_data;
  logic [CW-1:0] tx_cnt;
  uhi_tx_e tx_state_r;
  logic [9:0] tx_shift_r;
  logic [3:0] tx_bit_r;
  logic [TW-1:0] tx_tmr_r;
  // Receive side
  uhi_rx_e rx_state_r;
  logic [TW-1:0] rx_tmr_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  logic rx_chr_valid_r;
  logic [uhi_pkg::CHR_W-1:0] rx_chr_r;
  logic skid_in_ready, skid_out_valid, rx_room, rx_in_ready, rx_push;
  logic [uhi_pkg::CHR_W-1:0] skid_out_data, rx_out_data;
  logic rx_out_valid, rx_pop;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] err_cnt_r;
  // Status and interrupts
  logic oe_r, fe_r, bi_r;
  logic [3:0] msr_delta_r;
  logic tx_pend_r, xoff_pend_r, cts_pend_r, rts_pend_r;
  logic rx_pend;
  logic [7:0] line_status, modem_status, pend, interrupt_identify;

  // ==========================================================
  // Pin synchronisers and bus decode
  uhi_sync #(.W(uhi_pkg::PIN_N), .RST(uhi_pkg::PIN_RST)) u_sync (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in({carrier_detect_in, ring_indicator_in, data_set_ready_in,
             clear_to_send_in, serial_rx_in}),
    .pin_out(pins)
  );

  // Strobe decode per register
  assign wr_data = bus_wr_in && (bus_addr_in == uhi_pkg::OFS_DATA);
  assign wr_ier = bus_wr_in && (bus_addr_in == uhi_pkg::OFS_IER);
  assign wr_fcr = bus_wr_in && (bus_addr_in == uhi_pkg::OFS_ISR_FCR);
  assign wr_mcr = bus_wr_in && (bus_addr_in == uhi_pkg::OFS_MCR);
  assign rd_data = bus_rd_in && (bus_addr_in == uhi_pkg::OFS_DATA);
  assign rd_isr = bus_rd_in && (bus_addr_in == uhi_pkg::OFS_ISR_FCR);
  assign rd_lsr = bus_rd_in && (bus_addr_in == uhi_pkg::OFS_LSR);
  assign rd_msr = bus_rd_in && (bus_addr_in == uhi_pkg::OFS_MSR);
  assign fifo_en = fcr_r[uhi_pkg::FCR_EN];

  // Changing the FIFO mode flushes stale characters
  assign tx_flush = wr_fcr && (bus_wdata_in[uhi_pkg::FCR_TXRST] ||
    (bus_wdata_in[uhi_pkg::FCR_EN] != fifo_en));
  assign rx_flush = wr_fcr && (bus_wdata_in[uhi_pkg::FCR_RXRST] ||
    (bus_wdata_in[uhi_pkg::FCR_EN] != fifo_en));

  // Control registers; enables all clear at reset
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      ier_r <= uhi_pkg::REG_RST;
      fcr_r <= uhi_pkg::REG_RST;
      mcr_r <= uhi_pkg::REG_RST;
    end
    else
    begin
      if (wr_ier)
        ier_r <= bus_wdata_in;
      if (wr_fcr)
        fcr_r <= bus_wdata_in & ~8'h06; // Reset bits self-clear
      if (wr_mcr)
        mcr_r <= bus_wdata_in;
    end
  end

  // ==========================================================
  // Transmit path
  uhi_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .flush_in(tx_flush),
    .in_valid_in(wr_data && (fifo_en || tx_cnt == '0)),
    .in_ready_out(tx_in_ready),
    .in_data_in(bus_wdata_in),
    .out_valid_out(tx_out_valid),
    .out_ready_in(tx_pop),
    .out_data_out(tx_out_data),
    .count_out(tx_cnt)
  );
  assign tx_pop = (tx_state_r == TX_IDLE) && tx_out_valid;
  assign tx_empty = (tx_cnt == '0);

  // Shifter: start bit, eight data bits, stop bit
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 10'h3FF;
      tx_bit_r <= 4'h0;
      tx_tmr_r <= '0;
      serial_tx_out <= 1'b1;
    end
    else
    begin
      case (tx_state_r)
        TX_IDLE:
        begin
          serial_tx_out <= 1'b1;
          if (tx_pop)
          begin
            tx_shift_r <= {1'b1, tx_out_data, 1'b0};
            tx_bit_r <= 4'h0;
            tx_tmr_r <= '0;
            tx_state_r <= TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          serial_tx_out <= tx_shift_r[0];
          if (tx_tmr_r == BIT_LAST)
          begin
            tx_tmr_r <= '0;
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == TX_LAST)
              tx_state_r <= TX_IDLE;
          end
          else
            tx_tmr_r <= tx_tmr_r + 1'b1;
        end
        default:
          tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receiver with false-start rejection
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rx_state_r <= RX_IDLE;
      rx_tmr_r <= '0;
      rx_bit_r <= 4'h0;
      rx_shift_r <= uhi_pkg::REG_RST;
      rx_chr_valid_r <= 1'b0;
      rx_chr_r <= '0;
    end
    else
    begin
      rx_chr_valid_r <= 1'b0;
      case (rx_state_r)
        RX_IDLE:
        begin
          rx_tmr_r <= '0;
          if (pins_prev_r[uhi_pkg::PIN_RX] && !pins[uhi_pkg::PIN_RX])
            rx_state_r <= RX_START;
        end
        RX_START:
        begin
          // Mid start bit: still low accepts, high aborts
          if (rx_tmr_r == START_LAST)
          begin
            rx_tmr_r <= '0;
            rx_bit_r <= 4'h0;
            rx_state_r <= pins[uhi_pkg::PIN_RX] ? RX_IDLE : RX_DATA;
          end
          else
            rx_tmr_r <= rx_tmr_r + 1'b1;
        end
        RX_DATA:
        begin
          if (rx_tmr_r == BIT_LAST)
          begin
            rx_tmr_r <= '0;
            rx_shift_r <= {pins[uhi_pkg::PIN_RX], rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == DATA_LAST)
              rx_state_r <= RX_STOP;
          end
          else
            rx_tmr_r <= rx_tmr_r + 1'b1;
        end
        RX_STOP:
        begin
          if (rx_tmr_r == BIT_LAST)
          begin
            rx_chr_valid_r <= 1'b1;
            rx_chr_r <= {!pins[uhi_pkg::PIN_RX] && (rx_shift_r == 8'h00),
                         !pins[uhi_pkg::PIN_RX], rx_shift_r};
            rx_state_r <= RX_IDLE;
          end
          else
            rx_tmr_r <= rx_tmr_r + 1'b1;
        end
        default:
          rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Two-entry skid holds up to two words while the receive FIFO is busy
  uhi_fifo #(.W(uhi_pkg::CHR_W), .DEPTH(2)) u_rx_skid (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .flush_in(rx_flush),
    .in_valid_in(rx_chr_valid_r),
    .in_ready_out(skid_in_ready),
    .in_data_in(rx_chr_r),
    .out_valid_out(skid_out_valid),
    .out_ready_in(rx_room),
    .out_data_out(skid_out_data),
    .count_out()
  );

  // Single-character mode caps the receive FIFO at one
  assign rx_room = rx_in_ready && (fifo_en || rx_cnt == '0);
  assign rx_push = skid_out_valid && rx_room;
  assign rx_pop = rd_data && rx_out_valid;

  uhi_fifo #(.W(uhi_pkg::CHR_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .flush_in(rx_flush),
    .in_valid_in(rx_push),
    .in_ready_out(rx_in_ready),
    .in_data_in(skid_out_data),
    .out_valid_out(rx_out_valid),
    .out_ready_in(rx_pop),
    .out_data_out(rx_out_data),
    .count_out(rx_cnt)
  );

  // Errored characters currently held in the receive FIFO
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || rx_flush)
      err_cnt_r <= '0;
    else
    begin
      logic in_err;
      logic out_err;
      in_err = rx_push && (skid_out_data[uhi_pkg::CHR_BRK:uhi_pkg::CHR_FE]
        != 2'b00);
      out_err = rx_pop && (rx_out_data[uhi_pkg::CHR_BRK:uhi_pkg::CHR_FE]
        != 2'b00);
      if (in_err && !out_err)
        err_cnt_r <= err_cnt_r + 1'b1;
      else if (out_err && !in_err)
        err_cnt_r <= err_cnt_r - 1'b1;
    end
  end

  // ==========================================================
  // Line and modem status; a set in the clearing cycle wins
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      oe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      msr_delta_r <= 4'h0;
      pins_prev_r <= uhi_pkg::PIN_RST;
    end
    else
    begin
      pins_prev_r <= pins;
      oe_r <= (rx_chr_valid_r && !skid_in_ready) || (oe_r && !rd_lsr);
      fe_r <= (rx_chr_valid_r && rx_chr_r[uhi_pkg::CHR_FE]) ||
        (fe_r && !rd_lsr);
      bi_r <= (rx_chr_valid_r && rx_chr_r[uhi_pkg::CHR_BRK]) ||
        (bi_r && !rd_lsr);
      // Delta CTS, delta DSR, trailing ring edge, delta carrier
      msr_delta_r <= (rd_msr ? 4'h0 : msr_delta_r) | {
        pins[uhi_pkg::PIN_CD] ^ pins_prev_r[uhi_pkg::PIN_CD],
        pins_prev_r[uhi_pkg::PIN_RI] & ~pins[uhi_pkg::PIN_RI],
        pins[uhi_pkg::PIN_DSR] ^ pins_prev_r[uhi_pkg::PIN_DSR],
        pins[uhi_pkg::PIN_CTS] ^ pins_prev_r[uhi_pkg::PIN_CTS]};
    end
  end

  // Line status word
  always_comb
  begin
    line_status = 8'h00;
    line_status[uhi_pkg::LSR_DR] = (rx_cnt != '0);
    line_status[uhi_pkg::LSR_OE] = oe_r;
    line_status[uhi_pkg::LSR_PE] = 1'b0; // No parity in this frame format
    line_status[uhi_pkg::LSR_FE] = fe_r;
    line_status[uhi_pkg::LSR_BI] = bi_r;
    line_status[uhi_pkg::LSR_THRE] = tx_empty;
    line_status[uhi_pkg::LSR_TEMT] = tx_empty && (tx_state_r == TX_IDLE);
    line_status[uhi_pkg::LSR_FERR] = (err_cnt_r != '0);
  end
  assign modem_status = {pins[uhi_pkg::PIN_CD], pins[uhi_pkg::PIN_RI],
                pins[uhi_pkg::PIN_DSR], pins[uhi_pkg::PIN_CTS], msr_delta_r};

  // ==========================================================
  // Interrupt sources
  always_comb
  begin
    case (fcr_r[uhi_pkg::FCR_TRIG_HI:uhi_pkg::FCR_TRIG_LO])
      2'b00: trig = uhi_pkg::TRIG_L0;
      2'b01: trig = uhi_pkg::TRIG_L1;
      2'b10: trig = uhi_pkg::TRIG_L2;
      default: trig = uhi_pkg::TRIG_L3;
    endcase
  end
  // Trigger level in FIFO mode, any data otherwise
  assign rx_pend = fifo_en ? (rx_cnt >= CW'(trig)) : (rx_cnt != '0);

  // XOFF, CTS and RTS events latch only while enabled, the transmit one always; set beats clear
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      tx_pend_r <= 1'b0;
      tx_empty_prev_r <= 1'b1;
      xoff_pend_r <= 1'b0;
      cts_pend_r <= 1'b0;
      rts_pend_r <= 1'b0;
    end
    else
    begin
      tx_empty_prev_r <= tx_empty;
      // Empty after draining, or enabled while already empty
      tx_pend_r <= (tx_empty && !tx_empty_prev_r) ||
        (wr_ier && bus_wdata_in[uhi_pkg::IER_TX] &&
         !ier_r[uhi_pkg::IER_TX] && tx_empty) ||
        (tx_pend_r && !rd_isr && !wr_data);
      xoff_pend_r <= (ier_r[uhi_pkg::IER_XOFF] && rx_chr_valid_r &&
        rx_chr_r == {2'b00, XOFF_CHAR}) ||
        (xoff_pend_r && !rd_isr && ier_r[uhi_pkg::IER_XOFF]);
      cts_pend_r <= (ier_r[uhi_pkg::IER_CTS] && pins[uhi_pkg::PIN_CTS] &&
        !pins_prev_r[uhi_pkg::PIN_CTS]) ||
        (cts_pend_r && !rd_isr && ier_r[uhi_pkg::IER_CTS]);
      rts_pend_r <= (ier_r[uhi_pkg::IER_RTS] && wr_mcr &&
        bus_wdata_in[uhi_pkg::MCR_RTS] && !mcr_r[uhi_pkg::MCR_RTS]) ||
        (rts_pend_r && !rd_isr && ier_r[uhi_pkg::IER_RTS]);
    end
  end

  // Enabled pending sources; low enables cleared leave polling only
  always_comb
  begin
    pend = 8'h00;
    pend[uhi_pkg::ISR_LS] = ier_r[uhi_pkg::IER_LS] && (line_status[4:1] != 4'h0);
    pend[uhi_pkg::ISR_RX] = ier_r[uhi_pkg::IER_RX] && rx_pend;
    pend[uhi_pkg::ISR_TX] = ier_r[uhi_pkg::IER_TX] && tx_pend_r;
    pend[uhi_pkg::ISR_MS] = ier_r[uhi_pkg::IER_MS] && (msr_delta_r != 4'h0);
    pend[uhi_pkg::ISR_XOFF] = xoff_pend_r;
    pend[uhi_pkg::ISR_CTS] = cts_pend_r;
    pend[uhi_pkg::ISR_RTS] = rts_pend_r;
    interrupt_identify = pend;
    interrupt_identify[uhi_pkg::ISR_NONE] = (pend == 8'h00);
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      channel_irq_out <= 1'b0;
      sleep_out <= 1'b0;
      request_to_send_out <= 1'b0;
    end
    else
    begin
      channel_irq_out <= (pend != 8'h00);
      // Sleep only when idle, so no character is cut short
      sleep_out <= ier_r[uhi_pkg::IER_SLEEP] && (pend == 8'h00) &&
        tx_empty && (tx_state_r == TX_IDLE) && (rx_cnt == '0) &&
        (rx_state_r == RX_IDLE) && !skid_out_valid;
      request_to_send_out <= wr_mcr ? bus_wdata_in[uhi_pkg::MCR_RTS] :
        mcr_r[uhi_pkg::MCR_RTS];
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      bus_rdata_out <= uhi_pkg::REG_RST;
    else if (bus_rd_in)
    begin
      case (bus_addr_in)
        uhi_pkg::OFS_DATA: bus_rdata_out <= rx_out_valid ?
          rx_out_data[7:0] : uhi_pkg::REG_RST;
        uhi_pkg::OFS_IER: bus_rdata_out <= ier_r;
        uhi_pkg::OFS_ISR_FCR: bus_rdata_out <= interrupt_identify;
        uhi_pkg::OFS_MCR: bus_rdata_out <= mcr_r;
        uhi_pkg::OFS_LSR: bus_rdata_out <= line_status;
        uhi_pkg::OFS_MSR: bus_rdata_out <= modem_status;
        default: bus_rdata_out <= uhi_pkg::REG_RST;
      endcase
    end
  end
endmodule : uhi_top

// ### tb/uhi_line_src.sv
// Far-end serial transmitter model.
// Assumes 8N1 framing, bit time in system clocks.
`timescale 1ns/1ns
module uhi_line_src #(
  parameter int BIT_CLK = 32
) (
  input wire logic sys_clk_in,
  output logic line_out
);
  // ======
  // Idle line rests high between frames
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out = f[i];
      repeat (BIT_CLK) @(negedge sys_clk_in);
    end
  endtask : send
  // Low pulse far shorter than half a bit
  task automatic glitch(input int n);
    line_out = 1'b0;
    repeat (n) @(negedge sys_clk_in);
    line_out = 1'b1;
  endtask : glitch
endmodule : uhi_line_src

// ### tb/uhi_monitor.sv
// Port checker for uhi_top, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module uhi_monitor (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [2:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [7:0] bus_rdata_out,
  input wire logic serial_tx_out,
  input wire logic clear_to_send_in,
  input wire logic request_to_send_out,
  input wire logic channel_irq_out,
  input wire logic sleep_out
);
  logic [7:0] ier_r;
  logic [1:0] quiet_r;
  // ======
  // Shadow of the enables
  always_ff @(posedge sys_clk_in)
    if (srst_in)
      ier_r <= 8'h00;
    else if (bus_wr_in && bus_addr_in == 3'h1)
      ier_r <= bus_wdata_in;
  // Waits out the lag of pending latches after enables drop
  always_ff @(posedge sys_clk_in)
    if (srst_in || ier_r != 8'h00)
      quiet_r <= 2'h0;
    else if (quiet_r != 2'h3)
      quiet_r <= quiet_r + 2'h1;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  AST_IER_READ: assert property (bus_rd_in && bus_addr_in == 3'h1 |=>
    bus_rdata_out == $past(ier_r)) else $error("enable readback");
  AST_RDATA_HOLD: assert property (!$past(bus_rd_in) |->
    $stable(bus_rdata_out)) else $error("read data moved");
  AST_RTS_SET: assert property (bus_wr_in && bus_addr_in == 3'h4 &&
    bus_wdata_in[1] |-> ##2 request_to_send_out) else $error("rts");
  AST_START_LOW: assert property ($fell(serial_tx_out) |->
    (!serial_tx_out) [*8]) else $error("start bit short");
  AST_QUIET: assert property (quiet_r == 2'h3 |->
    !channel_irq_out) else $error("irq with no enables");
  AST_NO_SLEEP: assert property (!ier_r[4] && !$past(ier_r[4]) |->
    !sleep_out) else $error("sleep while disabled");
  AST_CTS_IRQ: assert property (ier_r[7] && $rose(clear_to_send_in) |->
    ##[1:10] channel_irq_out) else $error("cts irq missing");
  AST_ISR_NONE: assert property (quiet_r == 2'h3 && bus_rd_in &&
    bus_addr_in == 3'h2 |=> bus_rdata_out[0]) else $error("identify");
endmodule : uhi_monitor
bind uhi_top uhi_monitor u_mon (.*);

// ### tb/uhi_top_tb.sv
// Bench for uhi_top: registers, rx, tx, interrupts.
// Assumes DIV16 of 2, so one bit is 32 clocks.
`timescale 1ns/1ns
module uhi_top_tb;
  localparam logic [7:0] TXB = 8'h96;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cts = 1'b0;
  logic dsr = 1'b0;
  logic ri = 1'b0;
  logic cd = 1'b0;
  logic rts;
  logic rx, tx, irq, slp;
  logic [7:0] rdat;
  int fail_count = 0;
  int n_compared = 0;
  // Rows: address, data written, data read back
  logic [18:0] rows [4] = '{19'h1A5A5, 19'h3FF00, 19'h7FF00, 19'h10000};
  always #10 clk = ~clk;
  uhi_top #(.DIV16(2), .FIFO_DEPTH(32)) u_dut (
    .sys_clk_in(clk), .srst_in(srst), .bus_addr_in(addr),
    .bus_wdata_in(wd), .bus_wr_in(wr), .bus_rd_in(rd),
    .bus_rdata_out(rdat), .serial_rx_in(rx), .serial_tx_out(tx),
    .clear_to_send_in(cts), .data_set_ready_in(dsr),
    .ring_indicator_in(ri), .carrier_detect_in(cd),
    .request_to_send_out(rts), .channel_irq_out(irq), .sleep_out(slp));
  uhi_line_src u_line (.sys_clk_in(clk), .line_out(rx));
  // ======
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  // Strobes last one cycle; next access waits a cycle
  task automatic bw(input logic [2:0] a, input logic [7:0] d);
    {addr, wd, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : bw
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(rdat, e);
  endtask : rc
  // Sleep and irq after the sync and register lag
  task automatic ci(input logic [1:0] e);
    repeat (12) @(negedge clk);
    chk({6'h0, slp, irq}, {6'h0, e});
  endtask : ci
  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // ======
  initial
  begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rc(3'h1, 8'h00);
    rc(3'h5, 8'h60);
    foreach (rows[i])
    begin
      bw(rows[i][18:16], rows[i][15:8]);
      rc(rows[i][18:16], rows[i][7:0]);
    end
    rc(3'h2, 8'h01);
    bw(3'h2, 8'h01);
    bw(3'h1, 8'h01);
    u_line.send(8'hA1);
    repeat (6) u_line.send(8'h3C);
    ci(2'b00);
    u_line.send(8'hC3);
    ci(2'b01);
    rc(3'h2, 8'h04);
    rc(3'h5, 8'h61);
    rc(3'h0, 8'hA1);
    ci(2'b00);
    rc(3'h0, 8'h3C);
    bw(3'h2, 8'h03);
    u_line.glitch(6);
    repeat (400) @(negedge clk);
    rc(3'h5, 8'h60);
    bw(3'h1, 8'h02);
    ci(2'b01);
    bw(3'h0, TXB);
    for (int i = 0; i < 50 && tx; i++)
      @(negedge clk);
    repeat (16) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (32) @(negedge clk);
      chk({7'h0, tx}, {7'h0, TXB[i]});
    end
    rc(3'h5, 8'h20);
    // Stop bit runs a full bit time before the shifter idles
    repeat (60) @(negedge clk);
    rc(3'h5, 8'h60);
    rc(3'h2, 8'h08);
    ci(2'b00);
    bw(3'h1, 8'hC0);
    cts = 1'b1;
    ci(2'b01);
    rc(3'h2, 8'h40);
    bw(3'h4, 8'h02);
    chk({7'h0, rts}, 8'h01);
    ci(2'b01);
    rc(3'h2, 8'h80);
    // Clear the old CTS delta so only the DSR change can fire
    rc(3'h6, 8'h11);
    bw(3'h1, 8'h08);
    ci(2'b00);
    dsr = 1'b1;
    ci(2'b01);
    rc(3'h6, 8'h32);
    ci(2'b00);
    bw(3'h1, 8'h10);
    ci(2'b10);
    bw(3'h1, 8'h20);
    u_line.send(8'h13);
    ci(2'b01);
    rc(3'h2, 8'h20);
    bw(3'h1, 8'h00);
    u_line.send(8'h5A);
    ci(2'b00);
    rc(3'h5, 8'h61);
    bw(3'h1, 8'hFF);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rc(3'h1, 8'h00);
    ci(2'b00);
    report_and_stop();
  end
  // Watchdog: the cases need about 4200 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule : uhi_top_tb
